/* File: hw/packet_data_element_codec.sv */
// packet data element codec: option list parser, set header framer, field codecs
//
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps

module pdec_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr, rd_ptr;
  logic full, empty;
  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (in_valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wr_ptr <= '0;
    end else if (in_valid && !full) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rd_ptr <= '0;
    end else if (out_ready && !empty) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

module packet_data_element_codec
  import pdec_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready
);
  logic wr_ok, rd_ok, wr_elem_rx, wr_rr_rx;
  logic [31:0] be_mask, next_readdata, rr_rx_word, elem_rx_word;
  elem_t elem_cfg, elem_rx;
  resreq_t rr_cfg, rr_dec;
  logic [11:0] rr_enc;
  logic [3:0] enc_len;
  logic err_thr, err_ready, set_dropped, tx_busy;
  logic [15:0] last_id, cur_id;
  tx_set_t tx_set;
  logic [1:0] tx_idx;
  logic [7:0] in_byte, body_left;
  logic in_valid, in_last, accept, consume, next_in_valid, keep, body_first, supported;
  dec_state_t dstate;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_pop;
  rx_word_t fifo_in, fifo_out;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // one wait cycle per access: the request is answered at the second edge
  assign wr_ok = write && !waitrequest;
  assign rd_ok = read && !waitrequest;
  assign be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}},
                    {8{byteenable[0]}}};
  assign wr_elem_rx = wr_ok && (address == REG_ELEM_RX);
  assign wr_rr_rx = wr_ok && (address == REG_RR_RX);
  assign rr_rx_word = writedata & be_mask;
  assign elem_rx_word = ({24'h000000, elem_rx} & ~be_mask) | (writedata & be_mask);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !((read || write) && waitrequest);
    end
  end

  always_comb begin
    next_readdata = 32'h00000000;
    case (address)
      REG_ELEM_CFG: next_readdata = {24'h000000, elem_cfg};
      REG_RR_CFG: next_readdata = {20'h00000, rr_cfg};
      REG_RR_ENC: next_readdata = {12'h000, enc_len, 4'h0, rr_enc};
      REG_RR_DEC: next_readdata = {20'h00000, rr_dec};
      REG_STATUS: next_readdata = {last_id, 11'h000, tx_busy, !fifo_out_valid,
                                   set_dropped, err_ready, err_thr};
      REG_RX_DATA: next_readdata = {22'h000000, fifo_out_valid, fifo_out};
      REG_TX_SET: next_readdata = {tx_busy, 7'h00, tx_set};
      REG_ELEM_RX: next_readdata = {READY_MS[elem_rx.ready], 5'h00, elem_rx};
      default: next_readdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      readdata <= 32'h00000000;
    end else if (read && waitrequest) begin
      readdata <= next_readdata;
    end
  end

  // local element fields for transmission; priority and reply bit stored as coded
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      elem_cfg <= ELEM_RST;
    end else if (wr_ok && address == REG_ELEM_CFG) begin
      elem_cfg <= elem_t'(((32'(elem_cfg) & ~be_mask) | (writedata & be_mask)) >> 0);
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rr_cfg <= RR_RST;
    end else if (wr_ok && address == REG_RR_CFG) begin
      rr_cfg <= resreq_t'(((32'(rr_cfg) & ~be_mask) | (writedata & be_mask)) >> 0);
    end
  end

  // serialised resource request, left aligned in 12 bits
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rr_enc <= 12'h000;
      enc_len <= RR_LEN_SYM;
    end else if (rr_cfg.sym) begin
      rr_enc <= {rr_cfg.sym, rr_cfg.thr, rr_cfg.ul, rr_cfg.dl, rr_cfg.ful, rr_cfg.fdl};
      enc_len <= RR_LEN_ASYM;
    end else begin
      rr_enc <= {rr_cfg.sym, rr_cfg.thr, rr_cfg.ul, rr_cfg.ful, rr_cfg.fdl, 2'h0};
      enc_len <= RR_LEN_SYM;
    end
  end

  // received resource request, bits left aligned as on the wire
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rr_dec <= RR_RST;
    end else if (wr_rr_rx) begin
      rr_dec.sym <= rr_rx_word[11];
      rr_dec.thr <= rr_rx_word[10:8];
      rr_dec.ul <= rr_rx_word[7:6];
      if (rr_rx_word[11]) begin
        rr_dec.dl <= rr_rx_word[5:4];
        rr_dec.ful <= rr_rx_word[3:2];
        rr_dec.fdl <= rr_rx_word[1:0];
      end else begin
        rr_dec.dl <= rr_rx_word[7:6];
        rr_dec.ful <= rr_rx_word[5:4];
        rr_dec.fdl <= rr_rx_word[3:2];
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      elem_rx <= ELEM_RST;
    end else if (wr_elem_rx) begin
      elem_rx <= elem_rx_word[7:0];
    end
  end

  // sticky decode errors, write one to clear; a new error in the same cycle wins
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      err_thr <= 1'b0;
    end else if (wr_rr_rx && rr_rx_word[10:8] == THR_RESERVED) begin
      err_thr <= 1'b1;
    end else if (wr_ok && address == REG_STATUS && writedata[ST_THR_ERR]) begin
      err_thr <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      err_ready <= 1'b0;
    end else if (wr_elem_rx && (elem_rx_word[7:4] == READY_RSV_LO ||
                                elem_rx_word[7:4] == READY_RSV_HI)) begin
      err_ready <= 1'b1;
    end else if (wr_ok && address == REG_STATUS && writedata[ST_READY_ERR]) begin
      err_ready <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      set_dropped <= 1'b0;
    end else if (consume && dstate == D_LEN && !supported) begin
      set_dropped <= 1'b1;
    end else if (wr_ok && address == REG_STATUS && writedata[ST_DROP]) begin
      set_dropped <= 1'b0;
    end
  end

  // set header framer: protocol octet, id high, id low, length; contents follow elsewhere
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tx_set <= TX_SET_RST;
    end else if (wr_ok && address == REG_TX_SET && !tx_busy) begin
      tx_set <= tx_set_t'(((32'(tx_set) & ~be_mask) | (writedata & be_mask)) >> 0);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tx_busy <= 1'b0;
      tx_idx <= 2'h0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
    end else if (!tx_busy) begin
      if (wr_ok && address == REG_TX_SET && writedata[TX_GO_BIT] && byteenable[3]) begin
        tx_busy <= 1'b1;
        tx_idx <= 2'h0;
        tx_valid <= 1'b1;
        tx_data <= {CFG_PPP, 4'h0};
      end
    end else if (tx_ready) begin
      tx_idx <= tx_idx + 2'h1;
      case (tx_idx)
        2'h0: tx_data <= tx_set.id[15:8];
        2'h1: tx_data <= tx_set.id[7:0];
        2'h2: tx_data <= tx_set.len;
        default: begin
          tx_valid <= 1'b0;
          tx_busy <= 1'b0;
          tx_data <= 8'h00;
        end
      endcase
    end
  end

  // receive side: one octet holding stage keeps rx_ready a flop output
  assign accept = rx_valid && rx_ready;
  assign consume = in_valid && (dstate != D_BODY || !keep || fifo_in_ready);
  assign next_in_valid = (in_valid && !consume) || accept;
  assign supported = (cur_id == PID_PAP) || (cur_id == PID_CHAP);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      in_valid <= 1'b0;
      in_byte <= 8'h00;
      in_last <= 1'b0;
      rx_ready <= 1'b0;
    end else begin
      in_valid <= next_in_valid;
      rx_ready <= !next_in_valid;
      if (accept) begin
        in_byte <= rx_data;
        in_last <= rx_last;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dstate <= D_PROTO;
      cur_id <= 16'h0000;
      body_left <= 8'h00;
      keep <= 1'b0;
      body_first <= 1'b0;
      last_id <= 16'h0000;
    end else if (consume) begin
      case (dstate)
        D_PROTO: dstate <= D_IDHI;
        D_IDHI: begin
          cur_id[15:8] <= in_byte;
          dstate <= D_IDLO;
        end
        D_IDLO: begin
          cur_id[7:0] <= in_byte;
          dstate <= D_LEN;
        end
        D_LEN: begin
          body_left <= in_byte;
          keep <= supported;
          body_first <= 1'b1;
          last_id <= cur_id;
          dstate <= (in_byte == 8'h00) ? D_IDHI : D_BODY;
        end
        D_BODY: begin
          body_left <= body_left - 8'h01;
          body_first <= 1'b0;
          if (body_left == 8'h01) begin
            dstate <= D_IDHI;
          end
        end
        default: dstate <= D_PROTO;
      endcase
      if (in_last) begin
        dstate <= D_PROTO;
      end
    end
  end

  // contents octets pass unaltered; the ppp framing inside is software's business
  assign fifo_in_valid = in_valid && dstate == D_BODY && keep;
  assign fifo_in = '{start: body_first, data: in_byte};
  assign fifo_pop = rd_ok && address == REG_RX_DATA;

  pdec_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );
  property p_thr_err;
    (wr_rr_rx && rr_rx_word[10:8] == THR_RESERVED) |=> err_thr && rr_dec.thr == THR_RESERVED;
  endproperty
  a_thr_err: assert property (p_thr_err) else $error("reserved throughput not flagged");
  property p_ready_err;
    (wr_elem_rx && elem_rx_word[7:4] == READY_RSV_HI) |=> err_ready;
  endproperty
  a_ready_err: assert property (p_ready_err) else $error("reserved ready code not flagged");
  property p_sym_dl;
    !rr_dec.sym |-> rr_dec.dl == rr_dec.ul;
  endproperty
  a_sym_dl: assert property (p_sym_dl) else $error("symmetric downlink differs");
  property p_enc_len;
    $stable(rr_cfg) [*2] |-> enc_len == (rr_cfg.sym ? RR_LEN_ASYM : RR_LEN_SYM);
  endproperty
  a_enc_len: assert property (p_enc_len) else $error("resource request length wrong");
  property p_drop;
    (dstate == D_BODY && !keep) |-> !fifo_in_valid;
  endproperty
  a_drop: assert property (p_drop) else $error("dropped set reached buffer");
  property p_keep;
    (consume && dstate == D_LEN && in_byte != 8'h00 && !in_last && cur_id == PID_CHAP)
      |=> keep && dstate == D_BODY;
  endproperty
  a_keep: assert property (p_keep) else $error("chap set not kept");
  property p_empty_set;
    (consume && dstate == D_LEN && in_byte == 8'h00 && !in_last) |=> dstate == D_IDHI;
  endproperty
  a_empty_set: assert property (p_empty_set) else $error("zero length set mishandled");
  property p_tx_proto;
    $rose(tx_valid) |-> (tx_data == {CFG_PPP, 4'h0} && tx_idx == 2'h0) ##1 tx_valid;
  endproperty
  a_tx_proto: assert property (p_tx_proto) else $error("protocol octet not ppp");
  property p_tx_id;
    (tx_valid && tx_ready && tx_idx == 2'h0) |=> tx_data == tx_set.id[15:8];
  endproperty
  a_tx_id: assert property (p_tx_id) else $error("id high octet wrong");
  property p_bus_answer;
    ($rose(read) || $rose(write)) |-> ##[0:1] !waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus request not answered");
endmodule

/* File: hw/pdec_pkg.sv */
// shared constants, field layouts and types of the packet data element codec
package pdec_pkg;
  // register byte offsets on the avalon slave
  localparam logic [7:0] REG_ELEM_CFG = 8'h00;
  localparam logic [7:0] REG_RR_CFG = 8'h04;
  localparam logic [7:0] REG_RR_ENC = 8'h08;
  localparam logic [7:0] REG_RR_RX = 8'h0c;
  localparam logic [7:0] REG_RR_DEC = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_RX_DATA = 8'h18;
  localparam logic [7:0] REG_TX_SET = 8'h1c;
  localparam logic [7:0] REG_ELEM_RX = 8'h20;

  // field codes
  localparam logic [3:0] CFG_PPP = 4'h0;
  localparam logic [15:0] PID_PAP = 16'hc023;
  localparam logic [15:0] PID_CHAP = 16'hc223;
  localparam logic [2:0] THR_RESERVED = 3'h6;
  localparam logic [3:0] READY_RSV_LO = 4'h0;
  localparam logic [3:0] READY_RSV_HI = 4'hf;
  localparam logic [3:0] RR_LEN_SYM = 4'ha;
  localparam logic [3:0] RR_LEN_ASYM = 4'hc;
  localparam logic [1:0] TX_LAST_IDX = 2'h3;

  // bit positions
  localparam int ST_THR_ERR = 0;
  localparam int ST_READY_ERR = 1;
  localparam int ST_DROP = 2;
  localparam int ST_FIFO_EMPTY = 3;
  localparam int ST_TX_BUSY = 4;
  localparam int TX_GO_BIT = 31;

  // rx contents buffer
  localparam int FIFO_WIDTH = 9;
  localparam int FIFO_DEPTH = 32;

  // ready timer code to duration in ms, reserved codes give zero
  localparam logic [18:0] READY_MS [16] = '{
    19'h00000, 19'h000c8, 19'h001f4, 19'h002bc, 19'h003e8, 19'h007d0, 19'h00bb8, 19'h01388,
    19'h02710, 19'h04e20, 19'h07530, 19'h0ea60, 19'h1d4c0, 19'h2bf20, 19'h493e0, 19'h00000};

  typedef struct packed {
    logic [3:0] ready;
    logic reply;
    logic [2:0] prio;
  } elem_t;

  typedef struct packed {
    logic [1:0] fdl;
    logic [1:0] ful;
    logic [1:0] dl;
    logic [1:0] ul;
    logic [2:0] thr;
    logic sym;
  } resreq_t;

  typedef struct packed {
    logic start;
    logic [7:0] data;
  } rx_word_t;

  typedef struct packed {
    logic [7:0] len;
    logic [15:0] id;
  } tx_set_t;

  typedef enum logic [4:0] {
    D_PROTO = 5'b00001,
    D_IDHI = 5'b00010,
    D_IDLO = 5'b00100,
    D_LEN = 5'b01000,
    D_BODY = 5'b10000
  } dec_state_t;

  localparam elem_t ELEM_RST = 8'h00;
  localparam resreq_t RR_RST = 12'h000;
  localparam tx_set_t TX_SET_RST = 24'h000000;
endpackage

/* File: verification/peer_entity.sv */
// peer convergence entity model: feeds option-list octets and sinks set headers
`timescale 1ns/10ps
module peer_entity (
  input wire logic clk_sys,
  input wire logic rstn,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [8:0] rx_q [$];
  logic [7:0] tx_got [$];
  int n_sent;
  logic slow;
  logic [1:0] pace;

  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    tx_ready = 1'b1;
    slow = 1'b0;
    pace = 2'h0;
    n_sent = 0;
  end

  // octets leave in queue order: protocol octet, id high octet, id low, length, contents
  always @(posedge clk_sys) begin
    if (!rstn) begin
      rx_valid <= 1'b0;
    end else if (rx_valid && rx_ready) begin
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      // a released line must not keep showing the last octet
      rx_data <= ~rx_data;
      n_sent <= n_sent + 1;
    end else if (!rx_valid && rx_q.size() > 0) begin
      {rx_last, rx_data} <= rx_q.pop_front();
      rx_valid <= 1'b1;
    end
  end

  // slow mode offers ready one cycle in four to stretch the header
  always @(posedge clk_sys) begin
    pace <= pace + 2'h1;
    tx_ready <= !slow || pace == 2'h0;
    if (tx_valid && tx_ready) begin
      tx_got.push_back(tx_data);
    end
  end
endmodule

/* File: verification/test_packet_data_element_codec.sv */
// self-checking bench of the packet data element codec
`timescale 1ns/10ps
module test_packet_data_element_codec
  import pdec_pkg::*;
();
  logic clk_sys;
  logic rstn;
  logic [7:0] address;
  logic read, write;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata;
  logic waitrequest, rx_valid, rx_last, rx_ready, tx_valid, tx_ready;
  logic [7:0] rx_data, tx_data;
  int n_errors, checked;

  packet_data_element_codec uut (.clk_sys(clk_sys), .rstn(rstn), .address(address),
    .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));

  peer_entity peer (.clk_sys(clk_sys), .rstn(rstn), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until waitrequest is sampled low, released only after that edge
  task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    write <= wr_en;
    read <= !wr_en;
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (n >= 100) begin
      n_errors++;
      $display("MISMATCH bus answer expected %h seen %h", 1'b0, waitrequest);
      give_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask

  task automatic push(input logic [7:0] d, input logic l);
    peer.rx_q.push_back({l, d});
  endtask

  task automatic wait_sent(input int n);
    int k;
    k = 0;
    while (peer.n_sent < n && k < 3000) begin
      @(posedge clk_sys);
      k++;
    end
    chk("octets taken", n, peer.n_sent);
  endtask

  function automatic logic [31:0] enc(input resreq_t r);
    logic [11:0] b;
    b = r.sym ? {r.sym, r.thr, r.ul, r.dl, r.ful, r.fdl} : {r.sym, r.thr, r.ul, r.ful, r.fdl, 2'h0};
    return {12'h0, r.sym ? 4'hc : 4'ha, 4'h0, b};
  endfunction

  task automatic test_reset;
    logic [31:0] q;
    rd(REG_ELEM_CFG, q);
    chk("elem cfg reset", 32'h0, q);
    rd(REG_RR_CFG, q);
    chk("rr cfg reset", 32'h0, q);
    rd(REG_ELEM_RX, q);
    chk("elem rx reset", 32'h0, q);
    wr(8'h24, 32'hffffffff);
    rd(8'h24, q);
    chk("unmapped", 32'h0, q);
    $display("test reset done");
  endtask

  task automatic test_elem;
    logic [31:0] q;
    wr(REG_ELEM_CFG, 32'hfd);
    rd(REG_ELEM_CFG, q);
    chk("elem cfg", 32'hfd, q);
    wr(REG_ELEM_CFG, 32'h07);
    rd(REG_ELEM_CFG, q);
    chk("elem cfg", 32'h07, q);
    // lane 0 masked off: the stored fields must survive a write of zero
    byteenable <= 4'he;
    wr(REG_ELEM_CFG, 32'h00);
    byteenable <= 4'hf;
    rd(REG_ELEM_CFG, q);
    chk("elem cfg masked", 32'h07, q);
    $display("test elem done");
  endtask

  task automatic test_ready;
    logic [31:0] q;
    int ms [16] = '{0, 200, 500, 700, 1000, 2000, 3000, 5000, 10000, 20000, 30000,
      60000, 120000, 180000, 300000, 0};
    for (int c = 0; c < 16; c++) begin
      wr(REG_ELEM_RX, {24'h0, c[3:0], 4'h3});
      rd(REG_ELEM_RX, q);
      chk("ready ms", ms[c], q >> 13);
      chk("elem rx", {24'h0, c[3:0], 4'h3}, q & 32'hff);
      rd(REG_STATUS, q);
      chk("ready err", (c == 0 || c == 15) ? 32'h2 : 32'h0, q & 32'h2);
      wr(REG_STATUS, 32'h2);
    end
    $display("test ready done");
  endtask

  task automatic test_rr;
    logic [31:0] q, e;
    logic [2:0] v;
    resreq_t r, d;
    for (int i = 0; i < 8; i++) begin
      v = i[2:0];
      r = {v[1:0] ^ 2'h1, ~v[1:0], v[2:1], v[1:0], v, v[0]};
      e = enc(r);
      wr(REG_RR_CFG, {20'h0, r});
      rd(REG_RR_ENC, q);
      chk("rr enc", e, q);
      wr(REG_RR_RX, {20'h0, e[11:0]});
      d = r;
      if (!r.sym) begin
        d.dl = r.ul;
      end
      rd(REG_RR_DEC, q);
      chk("rr dec", {20'h0, d}, q);
      rd(REG_STATUS, q);
      chk("thr err", (v == 3'h6) ? 32'h1 : 32'h0, q & 32'h1);
      wr(REG_STATUS, 32'h1);
    end
    $display("test resource request done");
  endtask

  task automatic test_drop;
    logic [31:0] q;
    // a zero-length set sits before the last one; parsing must go on to the next id
    logic [7:0] seq [17] = '{8'hf0, 8'hc0, 8'h23, 8'h02, 8'haa, 8'hbb, 8'h12, 8'h34,
      8'h01, 8'hcc, 8'hc0, 8'h23, 8'h00, 8'hc2, 8'h23, 8'h01, 8'hdd};
    for (int i = 0; i < 17; i++) begin
      push(seq[i], i == 16);
    end
    wait_sent(17);
    rd(REG_RX_DATA, q);
    chk("rx octet", 32'h3aa, q);
    rd(REG_RX_DATA, q);
    chk("rx octet", 32'h2bb, q);
    rd(REG_RX_DATA, q);
    chk("rx octet", 32'h3dd, q);
    rd(REG_RX_DATA, q);
    chk("rx empty", 32'h0, q & 32'h200);
    rd(REG_STATUS, q);
    chk("drop flag", 32'hc, q & 32'hc);
    chk("last id", 32'hc223, q >> 16);
    wr(REG_STATUS, 32'h4);
    rd(REG_STATUS, q);
    chk("drop cleared", 32'h0, q & 32'h4);
    $display("test drop done");
  endtask

  task automatic test_fill;
    logic [31:0] q;
    push(8'h00, 1'b0);
    push(8'hc0, 1'b0);
    push(8'h23, 1'b0);
    push(8'h28, 1'b0);
    for (int i = 0; i < 40; i++) begin
      push(i[7:0], i == 39);
    end
    // the stream must stall once the buffer is full
    repeat (300) @(posedge clk_sys);
    chk("stream stalled", 32'h1, peer.n_sent < 61);
    for (int i = 0; i < 40; i++) begin
      rd(REG_RX_DATA, q);
      chk("rx fill octet", {22'h0, 1'b1, i == 0, i[7:0]}, q);
    end
    wait_sent(61);
    rd(REG_RX_DATA, q);
    chk("rx empty", 32'h0, q & 32'h200);
    rd(REG_STATUS, q);
    chk("last id", 32'hc023, q >> 16);
    $display("test fill done");
  endtask

  task automatic test_tx;
    logic [31:0] q;
    logic [7:0] hdr [4] = '{8'h00, 8'hc0, 8'h23, 8'h05};
    int k;
    peer.slow = 1'b1;
    wr(REG_TX_SET, 32'h8005c023);
    rd(REG_STATUS, q);
    chk("tx busy", 32'h10, q & 32'h10);
    // a second start while busy must not produce another header
    wr(REG_TX_SET, 32'h80011234);
    k = 0;
    while (peer.tx_got.size() < 4 && k < 500) begin
      @(posedge clk_sys);
      k++;
    end
    repeat (60) @(posedge clk_sys);
    chk("tx count", 32'h4, peer.tx_got.size());
    for (int i = 0; i < 4 && i < peer.tx_got.size(); i++) begin
      chk("tx octet", hdr[i], peer.tx_got[i]);
    end
    $display("test tx done");
  endtask

  initial begin
    #100000;
    n_errors++;
    $display("MISMATCH run time expected %0d seen %0d", 0, 1);
    give_verdict();
  end

  initial begin
    rstn = 1'b0;
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'hf;
    writedata = 32'h0;
    n_errors = 0;
    checked = 0;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    test_reset();
    test_elem();
    test_ready();
    test_rr();
    test_drop();
    test_fill();
    test_tx();
    give_verdict();
  end
endmodule
